// *** lfd_pkg.sv ***
`default_nettype none
package lfd_pkg;
    localparam logic [1:0] LFD_SEL_128A = 2'h0;
    localparam logic [1:0] LFD_SEL_192 = 2'h1;
    localparam logic [1:0] LFD_SEL_128B = 2'h2;
    localparam logic [1:0] LFD_SEL_256 = 2'h3;
    localparam int LFD_DIV_128 = 128;
    localparam int LFD_DIV_192 = 192;
    localparam int LFD_DIV_256 = 256;
    localparam int LFD_TICKS_LONG = 10;
    localparam int LFD_TICKS_SHORT = 2;
    localparam int LFD_ONLOAD_PERIODS = 64;
    localparam int LFD_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// *** lfd_channel.sv ***
`default_nettype none
module lfd_channel
    import lfd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic [3:0] expire_ticks,
    input wire logic gate_in,
    input wire logic pwm_start,
    input wire logic direct_pwm_mode,
    input wire logic battery_short_raw,
    input wire logic ground_short_raw,
    input wire logic open_load_raw,
    input wire logic diag_read,
    input wire logic fault_read,
    output logic battery_short_fault,
    output logic battery_short_tested,
    output logic ground_short_fault,
    output logic open_load_off_fault,
    output logic open_load_on_fault,
    output logic off_tested,
    output logic gate_kill
);
    logic gate_d_reg;
    logic [3:0] tested_cnt_reg;
    logic [3:0] sb_cnt_reg;
    logic [3:0] sg_cnt_reg;
    logic [3:0] ol_cnt_reg;
    logic sb_raw_d_reg;
    logic sg_raw_d_reg;
    logic ol_raw_d_reg;
    logic [6:0] on_periods_reg;
    logic gate_rise;
    logic gate_fall;
    logic tested_done;
    logic battery_short_filtered;
    logic ground_short_filtered;
    logic open_load_off_filtered;
    logic tested_hit;
    logic sb_set;
    logic sg_set;
    logic ol_set;

    assign gate_rise = gate_in && !gate_d_reg;
    assign gate_fall = !gate_in && gate_d_reg;
    assign tested_done = (tested_cnt_reg == expire_ticks);
    assign battery_short_filtered = battery_short_raw && (sb_cnt_reg == expire_ticks);
    // Off-state filters are held low while the gate is high. [RULE13]
    assign ground_short_filtered = !gate_in && ground_short_raw && (sg_cnt_reg == expire_ticks);
    assign open_load_off_filtered = !gate_in && open_load_raw && (ol_cnt_reg == expire_ticks);
    // Expiry is a one-cycle event, so a saturated timer cannot block a later read from clearing.
    assign tested_hit = tick && (tested_cnt_reg == expire_ticks - 4'h1);
    assign sb_set = battery_short_filtered && battery_short_tested && gate_in;
    assign sg_set = ground_short_filtered && off_tested;
    assign ol_set = !ground_short_filtered && open_load_off_filtered && off_tested;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gate_d_reg <= 1'b0;
            sb_raw_d_reg <= 1'b0;
            sg_raw_d_reg <= 1'b0;
            ol_raw_d_reg <= 1'b0;
        end else begin
            gate_d_reg <= gate_in;
            sb_raw_d_reg <= battery_short_raw;
            sg_raw_d_reg <= ground_short_raw;
            ol_raw_d_reg <= open_load_raw;
        end
    end

    // Tested timer restarts on either gate edge and on host reads. [RULE9] [RULE16] [RULE12] [RULE21]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tested_cnt_reg <= 4'h0;
        end else if (gate_rise || gate_fall || diag_read || fault_read) begin
            tested_cnt_reg <= 4'h0;
        end else if (tick && !tested_done) begin
            tested_cnt_reg <= tested_cnt_reg + 4'h1;
        end
    end

    // Filter timers start on raw rise, clear on fall and on gate edges. [RULE10] [RULE17] [RULE18] [RULE6]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sb_cnt_reg <= 4'h0;
            sg_cnt_reg <= 4'h0;
            ol_cnt_reg <= 4'h0;
        end else begin
            if (gate_rise || gate_fall || !battery_short_raw || !sb_raw_d_reg) begin
                sb_cnt_reg <= 4'h0;
            end else if (tick && sb_cnt_reg != expire_ticks) begin
                sb_cnt_reg <= sb_cnt_reg + 4'h1;
            end
            if (gate_rise || gate_fall || fault_read || !ground_short_raw || !sg_raw_d_reg) begin
                sg_cnt_reg <= 4'h0;
            end else if (tick && sg_cnt_reg != expire_ticks) begin
                sg_cnt_reg <= sg_cnt_reg + 4'h1;
            end
            if (gate_rise || gate_fall || fault_read || !open_load_raw || !ol_raw_d_reg) begin
                ol_cnt_reg <= 4'h0;
            end else if (tick && ol_cnt_reg != expire_ticks) begin
                ol_cnt_reg <= ol_cnt_reg + 4'h1;
            end
        end
    end

    // Sticky on-state bits; a new detection wins over a read in the same cycle. [RULE2] [RULE7]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            battery_short_tested <= 1'b0;
            battery_short_fault <= 1'b0;
        end else begin
            if ((gate_in && gate_d_reg && tested_hit) || sb_set) begin
                battery_short_tested <= 1'b1; // [RULE9] [RULE8]
            end else if (diag_read) begin
                battery_short_tested <= 1'b0; // [RULE12]
            end
            if (sb_set) begin
                battery_short_fault <= 1'b1; // [RULE11] [RULE8]
            end else if (diag_read) begin
                battery_short_fault <= 1'b0; // [RULE12]
            end
        end
    end

    // Fault forces the gate off until a diagnostic read clears the battery-short fault.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gate_kill <= 1'b0;
        end else if (battery_short_filtered && battery_short_tested && gate_in) begin
            gate_kill <= 1'b1; // [RULE11]
        end else if (!battery_short_fault) begin
            gate_kill <= 1'b0;
        end
    end

    // Off-state bits. [RULE16] [RULE19] [RULE20] [RULE21] [RULE8]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            off_tested <= 1'b0;
            ground_short_fault <= 1'b0;
            open_load_off_fault <= 1'b0;
        end else begin
            if ((!gate_in && !gate_d_reg && tested_hit) || sg_set || ol_set) begin
                off_tested <= 1'b1;
            end else if (fault_read) begin
                off_tested <= 1'b0;
            end
            if (sg_set) begin
                ground_short_fault <= 1'b1;
            end else if (fault_read) begin
                ground_short_fault <= 1'b0;
            end
            if (ol_set) begin
                open_load_off_fault <= 1'b1;
            end else if (fault_read) begin
                open_load_off_fault <= 1'b0;
            end
        end
    end

    // On-state open load counts whole PWM periods with the gate held high. [RULE14] [RULE15]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            on_periods_reg <= 7'h00;
            open_load_on_fault <= 1'b0;
        end else begin
            if (direct_pwm_mode) begin
                on_periods_reg <= 7'h00;
                open_load_on_fault <= 1'b0;
            end else begin
                if (!gate_in || diag_read) begin
                    on_periods_reg <= 7'h00;
                end else if (pwm_start && on_periods_reg != 7'(LFD_ONLOAD_PERIODS)) begin
                    on_periods_reg <= on_periods_reg + 7'h01;
                end
                if (gate_in && pwm_start && on_periods_reg == 7'(LFD_ONLOAD_PERIODS - 1)) begin
                    open_load_on_fault <= 1'b1;
                end else if (diag_read) begin
                    open_load_on_fault <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** lfd_diag.sv ***
`default_nettype none
// Behaviour
// [RULE1] Open-drain fault pin pulls low while any unmasked fault bit is set.
// [RULE2] Detected faults are sticky until the host reads their register.
// [RULE3] Falling reset edge latches reset-seen flag; generic flags read clears it.
// [RULE4] Enable low latches enable-low flag; cleared by read after enable returns high.
// [RULE5] Timer tick predivider is 128, 192, 128 or 256 by two-bit select.
// [RULE6] Tested and filter timers expire after 10-11 ticks, or 2-3 for select 10.
// [RULE7] Fault bits read 1 when detected; tested bits 1 after a completed test.
// [RULE8] A fault bit is never 1 while its tested bit is 0.
// [RULE9] Gate rise clears fault timers, starts tested timer; expiry sets battery-short-tested.
// [RULE10] Battery-short raw rise starts filter; expiry sets filtered; fall drops it at once.
// [RULE11] Filtered battery short with tested bit kills gate and sets fault bit.
// [RULE12] Diagnostic read clears battery-short fault, tested bit and tested timer.
// [RULE13] Battery short works in both modes; off-state filters held 0 while gate high.
// [RULE14] Direct PWM mode disables on-state open load; its bit stays 0.
// [RULE15] Gate high for 64 PWM periods sets on-state open load; read clears.
// [RULE16] Gate fall starts tested timer; expiry sets off-tested; reads restart it.
// [RULE17] Open-load raw rise starts filter; expiry sets filtered; fall clears at once.
// [RULE18] Ground-short raw rise restarts filter; expiry sets filtered; fall clears at once.
// [RULE19] Filtered ground short after tested expiry sets ground-short fault only.
// [RULE20] Filtered open load without ground short sets off-state open-load fault.
// [RULE21] Fault register read clears off-tested, ground-short and open-load-off bits and timers.
// [RULE22] Host commands zero current to tell ground short from open load.
// [RULE23] Each channel has its own timers and bits; predivider is shared.
module lfd_diag
    import lfd_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] diag_timebase_sel,
    input wire logic [CHANNELS-1:0] gate_drive_out,
    input wire logic [CHANNELS-1:0] pwm_start,
    input wire logic [CHANNELS-1:0] direct_pwm_mode,
    input wire logic [CHANNELS-1:0] battery_short_raw,
    input wire logic [CHANNELS-1:0] ground_short_raw,
    input wire logic [CHANNELS-1:0] open_load_raw,
    input wire logic [CHANNELS-1:0] diag_read,
    input wire logic [CHANNELS-1:0] fault_read,
    input wire logic [4:0] fault_mask,
    input wire logic enable_pin,
    input wire logic flags_read,
    output logic [CHANNELS-1:0] battery_short_fault,
    output logic [CHANNELS-1:0] battery_short_tested,
    output logic [CHANNELS-1:0] ground_short_fault,
    output logic [CHANNELS-1:0] open_load_off_fault,
    output logic [CHANNELS-1:0] open_load_on_fault,
    output logic [CHANNELS-1:0] off_tested,
    output logic [CHANNELS-1:0] gate_kill,
    output logic reset_seen_flag,
    output logic enable_low_flag,
    output logic fault_n_out,
    output logic fault_n_oe
);
    import lfd_pkg::*;

    if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
        $error("CHANNELS out of range");
    end

    logic [8:0] prediv_reg;
    logic [8:0] prediv_limit;
    logic tick_reg;
    logic [3:0] expire_ticks;
    logic [LFD_SYNC_STAGES-1:0] en_sync_reg;
    logic enable_now_reg;
    logic [CHANNELS-1:0] bsf;
    logic [CHANNELS-1:0] bst;
    logic [CHANNELS-1:0] sgf;
    logic [CHANNELS-1:0] olf;
    logic [CHANNELS-1:0] olnf;
    logic [CHANNELS-1:0] offt;
    logic [CHANNELS-1:0] kill;
    logic any_unmasked;

    // Shared predivider producing a one-cycle tick. [RULE5] [RULE23]
    always_comb begin
        case (diag_timebase_sel)
            LFD_SEL_192: prediv_limit = 9'(LFD_DIV_192 - 1);
            LFD_SEL_256: prediv_limit = 9'(LFD_DIV_256 - 1);
            default: prediv_limit = 9'(LFD_DIV_128 - 1);
        endcase
        // One extra tick absorbs the unknown phase of the free-running tick, giving 10 to 11 periods, or 2 to 3 for LFD_SEL_128B. [RULE6]
        expire_ticks = (diag_timebase_sel == LFD_SEL_128B) ? 4'(LFD_TICKS_SHORT + 1) : 4'(LFD_TICKS_LONG + 1);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prediv_reg <= 9'h000;
            tick_reg <= 1'b0;
        end else if (prediv_reg >= prediv_limit) begin
            prediv_reg <= 9'h000;
            tick_reg <= 1'b1;
        end else begin
            prediv_reg <= prediv_reg + 9'h001;
            tick_reg <= 1'b0;
        end
    end

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
            lfd_channel u_ch (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .tick(tick_reg),
                .expire_ticks(expire_ticks),
                .gate_in(gate_drive_out[ch]),
                .pwm_start(pwm_start[ch]),
                .direct_pwm_mode(direct_pwm_mode[ch]),
                .battery_short_raw(battery_short_raw[ch]),
                .ground_short_raw(ground_short_raw[ch]),
                .open_load_raw(open_load_raw[ch]),
                .diag_read(diag_read[ch]),
                .fault_read(fault_read[ch]),
                .battery_short_fault(bsf[ch]),
                .battery_short_tested(bst[ch]),
                .ground_short_fault(sgf[ch]),
                .open_load_off_fault(olf[ch]),
                .open_load_on_fault(olnf[ch]),
                .off_tested(offt[ch]),
                .gate_kill(kill[ch])
            ); // [RULE23]
        end
    endgenerate

    // Outputs are registered once more so every top output comes from a flop.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            battery_short_fault <= '0;
            battery_short_tested <= '0;
            ground_short_fault <= '0;
            open_load_off_fault <= '0;
            open_load_on_fault <= '0;
            off_tested <= '0;
            gate_kill <= '0;
        end else begin
            battery_short_fault <= bsf;
            battery_short_tested <= bst;
            ground_short_fault <= sgf;
            open_load_off_fault <= olf;
            open_load_on_fault <= olnf;
            off_tested <= offt;
            gate_kill <= kill;
        end
    end

    assign any_unmasked = (|bsf && !fault_mask[0]) || (|sgf && !fault_mask[1]) ||
                          (|olf && !fault_mask[2]) || (|olnf && !fault_mask[3]);

    // Open drain: only ever drives low. [RULE1]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_n_out <= 1'b0;
            fault_n_oe <= 1'b0;
        end else begin
            fault_n_out <= 1'b0;
            fault_n_oe <= any_unmasked;
        end
    end

    // The async reset itself marks the falling edge, so the flag is set under reset. [RULE3]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_seen_flag <= 1'b1;
        end else if (flags_read) begin
            reset_seen_flag <= 1'b0;
        end
    end

    // The enable pin is asynchronous, so it is synchronised and deglitched first.
    // The chain resets to the enabled level, so leaving reset reports no false low enable.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            en_sync_reg <= '1;
            enable_now_reg <= 1'b1;
        end else begin
            en_sync_reg <= {en_sync_reg[LFD_SYNC_STAGES-2:0], enable_pin};
            if (en_sync_reg[1] == en_sync_reg[2]) begin
                enable_now_reg <= en_sync_reg[2];
            end
        end
    end

    // Low enable sets; clear only after a read with enable back high. [RULE4]
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            enable_low_flag <= 1'b0;
        end else if (!enable_now_reg) begin
            enable_low_flag <= 1'b1;
        end else if (flags_read) begin
            enable_low_flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** lfd_diag_asserts.sv ***
`default_nettype none
module lfd_diag_asserts
    import lfd_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [CHANNELS-1:0] direct_pwm_mode,
    input wire logic [CHANNELS-1:0] diag_read,
    input wire logic [CHANNELS-1:0] fault_read,
    input wire logic [4:0] fault_mask,
    input wire logic enable_pin,
    input wire logic flags_read,
    input wire logic [CHANNELS-1:0] battery_short_fault,
    input wire logic [CHANNELS-1:0] battery_short_tested,
    input wire logic [CHANNELS-1:0] ground_short_fault,
    input wire logic [CHANNELS-1:0] open_load_off_fault,
    input wire logic [CHANNELS-1:0] open_load_on_fault,
    input wire logic [CHANNELS-1:0] off_tested,
    input wire logic [CHANNELS-1:0] gate_kill,
    input wire logic reset_seen_flag,
    input wire logic enable_low_flag,
    input wire logic fault_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fault_live;
    assign fault_live = (|battery_short_fault & !fault_mask[0]) | (|ground_short_fault & !fault_mask[1])
        | (|open_load_off_fault & !fault_mask[2]) | (|open_load_on_fault & !fault_mask[3]);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    pin_pulled_a: assert property (fault_live [*2] |-> fault_n_oe) else $error("fault pin idle");
    pin_released_a: assert property (!fault_live [*2] |-> !fault_n_oe) else $error("fault pin stuck");
    fault_tested_a: assert property (!(|(battery_short_fault & ~battery_short_tested)))
        else $error("fault without tested bit");
    direct_mode_a: assert property (!(|(direct_pwm_mode & $past(direct_pwm_mode, 1) & $past(direct_pwm_mode, 2)
        & open_load_on_fault)))
        else $error("on open load in direct mode");
    gate_kill_a: assert property ($rose(battery_short_fault[0]) |-> ##[0:1] gate_kill[0])
        else $error("gate not killed");
    diag_clear_a: assert property (diag_read[0] |-> ##3 !battery_short_fault[0])
        else $error("diag read did not clear");
    fault_clear_a: assert property (fault_read[0] |-> ##3 !(off_tested[0] | ground_short_fault[0]
        | open_load_off_fault[0])) else $error("fault read did not clear");
    reset_flag_a: assert property ($fell(reset_seen_flag) |-> $past(flags_read, 1) || $past(flags_read, 2)
        || $past(flags_read, 3)) else $error("reset flag lost");
    enable_set_a: assert property (!enable_pin [*8] |-> enable_low_flag) else $error("enable flag missing");
    enable_clr_a: assert property ($fell(enable_low_flag) |-> $past(flags_read, 1) || $past(flags_read, 2)
        || $past(flags_read, 3)) else $error("enable flag lost");
    cover property ($rose(battery_short_fault[0]));
    cover property ($rose(ground_short_fault[0]));
    cover property ($rose(open_load_on_fault[0]));
endmodule
bind lfd_diag lfd_diag_asserts #(.CHANNELS(CHANNELS)) u_lfd_diag_asserts (
    .sys_clk(sys_clk), .resetn(resetn), .direct_pwm_mode(direct_pwm_mode), .diag_read(diag_read),
    .fault_read(fault_read), .fault_mask(fault_mask), .enable_pin(enable_pin), .flags_read(flags_read),
    .battery_short_fault(battery_short_fault), .battery_short_tested(battery_short_tested),
    .ground_short_fault(ground_short_fault), .open_load_off_fault(open_load_off_fault),
    .open_load_on_fault(open_load_on_fault), .off_tested(off_tested), .gate_kill(gate_kill),
    .reset_seen_flag(reset_seen_flag), .enable_low_flag(enable_low_flag), .fault_n_oe(fault_n_oe)
);
`default_nettype wire

// *** lfd_host_model.sv ***
`default_nettype none
module lfd_host_model #(
    parameter int CHANNELS = 8
) (
    input wire logic sys_clk,
    output logic [CHANNELS-1:0] diag_read,
    output logic [CHANNELS-1:0] fault_read,
    output logic flags_read
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        diag_read = '0;
        fault_read = '0;
        flags_read = 1'h0;
    end
    // A read is a one-cycle strobe; holding it longer would count as several reads.
    task automatic read_msg(input int kind, input int ch);
        @(negedge sys_clk);
        case (kind)
            0: diag_read[ch] = 1'h1;
            1: fault_read[ch] = 1'h1;
            default: flags_read = 1'h1;
        endcase
        @(negedge sys_clk);
        diag_read = '0;
        fault_read = '0;
        flags_read = 1'h0;
    endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lfd_pkg::*;
    localparam int CH = 2;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic enable_pin = 1'h1;
    logic [1:0] sel = 2'h2;
    logic [4:0] fault_mask = 5'h00;
    logic [CH-1:0] gate = '0, pwm = '0, dmode = '0, sb_raw = '0, sg_raw = '0, ol_raw = '0;
    logic [CH-1:0] diag_read, fault_read, bsf, bst, gsf, olf, oon, offt, kill;
    logic flags_read, reset_seen_flag, enable_low_flag, fault_n_out, fault_n_oe;
    int mismatches = 0;
    int checks_done = 0;
    initial forever #4 sys_clk = ~sys_clk;
    lfd_diag #(.CHANNELS(CH)) u_lfd_diag (.sys_clk(sys_clk), .resetn(resetn), .diag_timebase_sel(sel),
        .gate_drive_out(gate), .pwm_start(pwm), .direct_pwm_mode(dmode), .battery_short_raw(sb_raw),
        .ground_short_raw(sg_raw), .open_load_raw(ol_raw), .diag_read(diag_read), .fault_read(fault_read),
        .fault_mask(fault_mask), .enable_pin(enable_pin), .flags_read(flags_read), .battery_short_fault(bsf),
        .battery_short_tested(bst), .ground_short_fault(gsf), .open_load_off_fault(olf),
        .open_load_on_fault(oon), .off_tested(offt), .gate_kill(kill), .reset_seen_flag(reset_seen_flag),
        .enable_low_flag(enable_low_flag), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe));
    lfd_host_model #(.CHANNELS(CH)) u_lfd_host_model (.sys_clk(sys_clk), .diag_read(diag_read),
        .fault_read(fault_read), .flags_read(flags_read));
    task automatic stop_test();
        $display("Counts: %0d mismatches, %0d checks", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            pwm = 2'h3;
            cyc(1);
            pwm = 2'h0;
            cyc(3);
        end
    endtask
    function automatic logic pick(input int w, input int c);
        case (w)
            0: return bst[c];
            1: return bsf[c];
            2: return gsf[c];
            3: return olf[c];
            4: return oon[c];
            default: return offt[c];
        endcase
    endfunction
    // Sampling on falling edges keeps every look clear of the rising-edge updates.
    task automatic wait_bit(input int w, input int c, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(w, c) !== 1'h1 && n < hi) begin
            cyc(1);
            n++;
        end
        chk("wait in bound", 1'h1, pick(w, c) === 1'h1 && n >= lo);
        if (pick(w, c) !== 1'h1) stop_test();
    endtask
    task automatic t_flags();
        chk("reset_seen", 1'h1, reset_seen_flag);
        chk("enable_low idle", 1'h0, enable_low_flag);
        u_lfd_host_model.read_msg(2, 0);
        cyc(4);
        chk("reset_seen clr", 1'h0, reset_seen_flag);
        enable_pin = 1'h0;
        cyc(10);
        chk("enable_low", 1'h1, enable_low_flag);
        u_lfd_host_model.read_msg(2, 0);
        cyc(4);
        chk("enable_low held", 1'h1, enable_low_flag);
        enable_pin = 1'h1;
        cyc(10);
        u_lfd_host_model.read_msg(2, 0);
        cyc(4);
        chk("enable_low clr", 1'h0, enable_low_flag);
        chk("reset_seen stays", 1'h0, reset_seen_flag);
        resetn = 1'h0;
        cyc(2);
        resetn = 1'h1;
        cyc(2);
        chk("reset_seen again", 1'h1, reset_seen_flag);
        chk("enable_low after reset", 1'h0, enable_low_flag);
    endtask
    task automatic t_timebase();
        int div [4] = '{128, 192, 128, 256};
        int tks [4] = '{10, 10, 2, 10};
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            u_lfd_host_model.read_msg(1, 0);
            cyc(3);
            chk("off_tested clr", 1'h0, offt[0]);
            wait_bit(5, 0, tks[s] * div[s] - 4, (tks[s] + 1) * div[s] + 8);
        end
    endtask
    task automatic t_battery();
        sel = 2'h2;
        sg_raw[0] = 1'h1;
        ol_raw[0] = 1'h1;
        gate[0] = 1'h1;
        cyc(100);
        chk("sb_tested early", 1'h0, bst[0]);
        wait_bit(0, 0, 20, 300);
        sb_raw[0] = 1'h1;
        wait_bit(1, 0, 100, 400);
        cyc(2);
        chk("gate_kill", 1'h1, kill[0]);
        chk("fault pin", 1'h1, fault_n_oe);
        chk("fault pin level", 1'h0, fault_n_out);
        fault_mask = 5'h01;
        cyc(3);
        chk("fault pin masked", 1'h0, fault_n_oe);
        fault_mask = 5'h00;
        sb_raw[0] = 1'h0;
        cyc(3);
        chk("sb fault sticky", 1'h1, bsf[0]);
        chk("other channel", 1'h0, bsf[1] | bst[1]);
        chk("off filters held", 1'h0, gsf[0] | olf[0]);
        u_lfd_host_model.read_msg(0, 0);
        cyc(3);
        chk("sb fault clr", 1'h0, bsf[0] | bst[0] | kill[0]);
        gate[0] = 1'h0;
        sg_raw[0] = 1'h0;
        ol_raw[0] = 1'h0;
    endtask
    task automatic t_offstate();
        u_lfd_host_model.read_msg(1, 0);
        cyc(3);
        wait_bit(5, 0, 100, 400);
        sg_raw[0] = 1'h1;
        wait_bit(2, 0, 100, 400);
        ol_raw[0] = 1'h1;
        cyc(500);
        chk("ol off unchanged", 1'h0, olf[0]);
        sg_raw[0] = 1'h0;
        ol_raw[0] = 1'h0;
        u_lfd_host_model.read_msg(1, 0);
        cyc(3);
        chk("fault read clr", 1'h0, offt[0] | gsf[0] | olf[0]);
        ol_raw[0] = 1'h1;
        wait_bit(3, 0, 100, 800);
        ol_raw[0] = 1'h0;
        u_lfd_host_model.read_msg(1, 0);
        cyc(3);
        chk("ol off clr", 1'h0, olf[0]);
    endtask
    task automatic t_onload();
        dmode = 2'h2;
        gate = 2'h3;
        pulses(62);
        chk("on open load early", 1'h0, oon[0]);
        pulses(4);
        chk("on open load", 1'h1, oon[0]);
        chk("direct pwm", 1'h0, oon[1]);
        u_lfd_host_model.read_msg(0, 0);
        cyc(3);
        chk("on open load clr", 1'h0, oon[0]);
        gate = 2'h0;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        cyc(1);
        resetn = 1'h1;
        cyc(2);
        t_flags();
        t_timebase();
        t_battery();
        t_offstate();
        t_onload();
        stop_test();
    end
endmodule
`default_nettype wire
